// ---- hw/acc_pkg.sv ----
// Constants shared by the analog comparator control logic.
package acc_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the APB
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLR   = 8'h0C;
	localparam logic [7:0] ADDR_EVT_COUNT = 8'h10;
	localparam logic [7:0] ADDR_LIVE      = 8'h14;

	// ----------------------------------------------------------------
	// Field positions of compare_status_control
	// ----------------------------------------------------------------
	localparam int BIT_MODULE_ENABLE    = 7;
	localparam int BIT_REFERENCE_SELECT = 6;
	localparam int BIT_EVENT_FLAG       = 5;
	localparam int BIT_IRQ_ENABLE       = 4;
	localparam int BIT_RESULT_STATUS    = 3;
	localparam int BIT_PIN_ENABLE       = 2;
	localparam int BIT_EDGE_MODE_HI     = 1;
	localparam int BIT_EDGE_MODE_LO     = 0;

	// ----------------------------------------------------------------
	// Interrupt status, enable and clear layout
	// ----------------------------------------------------------------
	localparam int IRQ_WIDTH       = 4;
	localparam int IRQ_BIT_COMPARE = 0;
	localparam int IRQ_BIT_RISE    = 1;
	localparam int IRQ_BIT_FALL    = 2;
	localparam int IRQ_BIT_LOST    = 3;

	// ----------------------------------------------------------------
	// Edge mode encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] EDGE_FALL_A = 2'h0;
	localparam logic [1:0] EDGE_RISE   = 2'h1;
	localparam logic [1:0] EDGE_FALL_B = 2'h2;
	localparam logic [1:0] EDGE_BOTH   = 2'h3;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_WIDTH  = 8;
	localparam int COUNT_WIDTH = 16;

	localparam logic [7:0]             CTRL_RESET    = 8'h00;
	localparam logic [IRQ_WIDTH-1:0]   IRQ_RESET     = 4'h0;
	localparam logic [COUNT_WIDTH-1:0] COUNT_RESET   = 16'h0000;
	localparam logic [31:0]            PRDATA_RESET  = 32'h0000_0000;

endpackage

// ---- hw/acc_sync_edge.sv ----
// Two-stage synchroniser with edge detection on the synchronised level.
`timescale 1ns/100ps

module acc_sync_edge (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output logic      sync_out,
	output logic      rise,
	output logic      fall
);

	// ----------------------------------------------------------------
	// Synchroniser
	// ----------------------------------------------------------------
	// The first stage may go metastable, so only the second stage reads it.
	logic meta;
	logic prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta     <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

	// ----------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= 1'b0;
		end else begin
			prev <= sync_out;
		end
	end

	assign rise = sync_out & ~prev;
	assign fall = ~sync_out & prev;

endmodule

// ---- hw/acc_top.sv ----
// Control and status logic around an analog voltage comparator, on APB.
`timescale 1ns/100ps

module acc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        compare_raw,
	input  wire logic        stop_wake_clear,
	input  wire logic        wait_mode,
	output logic             comparator_enable,
	output logic             reference_select,
	output logic             result_output_pin,
	output logic             result_output_pin_oe,
	output logic             irq,
	output logic             wake_request
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup_phase;
	logic access_phase;
	logic wr_access;
	logic rd_setup;
	logic addr_mapped;
	logic wr_lane0;
	logic hit_ctrl;
	logic hit_irq_en;
	logic hit_irq_clr;
	logic hit_count;

	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_access    = access_phase & pwrite;
	assign rd_setup     = setup_phase & ~pwrite;
	assign wr_lane0     = pstrb[0];

	always_comb begin
		unique case (paddr)
			acc_pkg::ADDR_CTRL,
			acc_pkg::ADDR_IRQ_STAT,
			acc_pkg::ADDR_IRQ_EN,
			acc_pkg::ADDR_IRQ_CLR,
			acc_pkg::ADDR_EVT_COUNT,
			acc_pkg::ADDR_LIVE: begin
				addr_mapped = 1'b1;
			end
			default: begin
				addr_mapped = 1'b0;
			end
		endcase
	end

	// Only lane 0 carries register bits, so a write without it is a no-op, except at the event counter, which any write clears.
	assign hit_ctrl    = wr_access & wr_lane0 & (paddr == acc_pkg::ADDR_CTRL);
	assign hit_irq_en  = wr_access & wr_lane0
		& (paddr == acc_pkg::ADDR_IRQ_EN);
	assign hit_irq_clr = wr_access & wr_lane0
		& (paddr == acc_pkg::ADDR_IRQ_CLR);
	assign hit_count   = wr_access & (paddr == acc_pkg::ADDR_EVT_COUNT);

	// The slave never inserts wait states.
	assign pready  = 1'b1;
	assign pslverr = access_phase & ~addr_mapped;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	logic       module_enable;
	logic       reference_sel;
	logic       compare_irq_enable;
	logic       result_pin_enable;
	logic [1:0] edge_mode;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			module_enable      <= acc_pkg::CTRL_RESET[acc_pkg::BIT_MODULE_ENABLE];
			reference_sel      <=
				acc_pkg::CTRL_RESET[acc_pkg::BIT_REFERENCE_SELECT];
			compare_irq_enable <= acc_pkg::CTRL_RESET[acc_pkg::BIT_IRQ_ENABLE];
			result_pin_enable  <= acc_pkg::CTRL_RESET[acc_pkg::BIT_PIN_ENABLE];
			edge_mode          <= acc_pkg::CTRL_RESET[
				acc_pkg::BIT_EDGE_MODE_HI:acc_pkg::BIT_EDGE_MODE_LO];
		end else if (stop_wake_clear) begin
			module_enable      <= acc_pkg::CTRL_RESET[acc_pkg::BIT_MODULE_ENABLE];
			reference_sel      <=
				acc_pkg::CTRL_RESET[acc_pkg::BIT_REFERENCE_SELECT];
			compare_irq_enable <= acc_pkg::CTRL_RESET[acc_pkg::BIT_IRQ_ENABLE];
			result_pin_enable  <= acc_pkg::CTRL_RESET[acc_pkg::BIT_PIN_ENABLE];
			edge_mode          <= acc_pkg::CTRL_RESET[
				acc_pkg::BIT_EDGE_MODE_HI:acc_pkg::BIT_EDGE_MODE_LO];
		end else if (hit_ctrl) begin
			module_enable      <= pwdata[acc_pkg::BIT_MODULE_ENABLE];
			reference_sel      <= pwdata[acc_pkg::BIT_REFERENCE_SELECT];
			compare_irq_enable <= pwdata[acc_pkg::BIT_IRQ_ENABLE];
			result_pin_enable  <= pwdata[acc_pkg::BIT_PIN_ENABLE];
			edge_mode          <= pwdata[
				acc_pkg::BIT_EDGE_MODE_HI:acc_pkg::BIT_EDGE_MODE_LO];
		end
	end

	assign comparator_enable = module_enable;
	assign reference_select  = reference_sel;

	// ----------------------------------------------------------------
	// Comparator result
	// ----------------------------------------------------------------
	// The analog core drives compare_raw high when its positive input is
	// above its negative input, so the level is used without inversion.
	logic result_sync;
	logic result_rise;
	logic result_fall;
	logic enabled_prev;
	logic result_live;

	acc_sync_edge u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (compare_raw),
		.sync_out (result_sync),
		.rise     (result_rise),
		.fall     (result_fall)
	);

	// Edges seen in the first cycle after enabling come from the core
	// settling, not from the inputs, so they are ignored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enabled_prev <= 1'b0;
		end else begin
			enabled_prev <= module_enable & ~stop_wake_clear;
		end
	end

	assign result_live = module_enable & result_sync;

	// ----------------------------------------------------------------
	// Compare event
	// ----------------------------------------------------------------
	// Wait mode does not gate anything here: an enabled comparator keeps
	// detecting events and raising its request.
	logic compare_event;
	logic edge_qual;

	assign edge_qual = module_enable & enabled_prev;

	always_comb begin
		unique case (edge_mode)
			acc_pkg::EDGE_FALL_A: begin
				compare_event = edge_qual & result_fall;
			end
			acc_pkg::EDGE_RISE: begin
				compare_event = edge_qual & result_rise;
			end
			acc_pkg::EDGE_FALL_B: begin
				compare_event = edge_qual & result_fall;
			end
			acc_pkg::EDGE_BOTH: begin
				compare_event = edge_qual & (result_rise | result_fall);
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Event flag
	// ----------------------------------------------------------------
	logic compare_event_flag;
	logic flag_clear;

	assign flag_clear = hit_ctrl & pwdata[acc_pkg::BIT_EVENT_FLAG];

	// A new event wins over a clear written in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_event_flag <= acc_pkg::CTRL_RESET[acc_pkg::BIT_EVENT_FLAG];
		end else if (stop_wake_clear) begin
			compare_event_flag <= acc_pkg::CTRL_RESET[acc_pkg::BIT_EVENT_FLAG];
		end else if (compare_event) begin
			compare_event_flag <= 1'b1;
		end else if (flag_clear) begin
			compare_event_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status, enable and clear
	// ----------------------------------------------------------------
	logic [acc_pkg::IRQ_WIDTH-1:0] irq_status;
	logic [acc_pkg::IRQ_WIDTH-1:0] irq_enable;
	logic [acc_pkg::IRQ_WIDTH-1:0] irq_events;
	logic [acc_pkg::IRQ_WIDTH-1:0] irq_clear;

	always_comb begin
		irq_events = acc_pkg::IRQ_RESET;
		irq_events[acc_pkg::IRQ_BIT_COMPARE] = compare_event;
		irq_events[acc_pkg::IRQ_BIT_RISE]    = edge_qual & result_rise;
		irq_events[acc_pkg::IRQ_BIT_FALL]    = edge_qual & result_fall;
		irq_events[acc_pkg::IRQ_BIT_LOST]    = compare_event
			& compare_event_flag & ~flag_clear;
	end

	assign irq_clear = hit_irq_clr ? pwdata[acc_pkg::IRQ_WIDTH-1:0]
		: acc_pkg::IRQ_RESET;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= acc_pkg::IRQ_RESET;
		end else if (stop_wake_clear) begin
			irq_status <= acc_pkg::IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable <= acc_pkg::IRQ_RESET;
		end else if (stop_wake_clear) begin
			irq_enable <= acc_pkg::IRQ_RESET;
		end else if (hit_irq_en) begin
			irq_enable <= pwdata[acc_pkg::IRQ_WIDTH-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Event counter
	// ----------------------------------------------------------------
	// Counts compare events and wraps; any write to it returns it to zero.
	logic [acc_pkg::COUNT_WIDTH-1:0] event_count;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_count <= acc_pkg::COUNT_RESET;
		end else if (stop_wake_clear | hit_count) begin
			event_count <= acc_pkg::COUNT_RESET;
		end else if (compare_event) begin
			event_count <= event_count
				+ {{(acc_pkg::COUNT_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and wake outputs
	// ----------------------------------------------------------------
	logic irq_level;

	assign irq_level = (compare_irq_enable & compare_event_flag)
		| (|(irq_status & irq_enable));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq          <= 1'b0;
			wake_request <= 1'b0;
		end else if (stop_wake_clear) begin
			// Dropped at once, so no stale request outlives the wake clear.
			irq          <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			irq          <= irq_level;
			wake_request <= irq_level & wait_mode;
		end
	end

	// ----------------------------------------------------------------
	// Result pin
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_output_pin    <= 1'b0;
			result_output_pin_oe <= 1'b0;
		end else if (stop_wake_clear) begin
			result_output_pin    <= 1'b0;
			result_output_pin_oe <= 1'b0;
		end else begin
			result_output_pin    <= result_pin_enable & result_live;
			result_output_pin_oe <= result_pin_enable;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [acc_pkg::CTRL_WIDTH-1:0] ctrl_view;
	logic [31:0]                    next_prdata;

	always_comb begin
		ctrl_view = acc_pkg::CTRL_RESET;
		ctrl_view[acc_pkg::BIT_MODULE_ENABLE]    = module_enable;
		ctrl_view[acc_pkg::BIT_REFERENCE_SELECT] = reference_sel;
		ctrl_view[acc_pkg::BIT_EVENT_FLAG]       = compare_event_flag;
		ctrl_view[acc_pkg::BIT_IRQ_ENABLE]       = compare_irq_enable;
		ctrl_view[acc_pkg::BIT_RESULT_STATUS]    = result_live;
		ctrl_view[acc_pkg::BIT_PIN_ENABLE]       = result_pin_enable;
		ctrl_view[acc_pkg::BIT_EDGE_MODE_HI:acc_pkg::BIT_EDGE_MODE_LO] =
			edge_mode;
	end

	always_comb begin
		next_prdata = acc_pkg::PRDATA_RESET;
		unique case (paddr)
			acc_pkg::ADDR_CTRL: begin
				next_prdata[acc_pkg::CTRL_WIDTH-1:0] = ctrl_view;
			end
			acc_pkg::ADDR_IRQ_STAT: begin
				next_prdata[acc_pkg::IRQ_WIDTH-1:0] = irq_status;
			end
			acc_pkg::ADDR_IRQ_EN: begin
				next_prdata[acc_pkg::IRQ_WIDTH-1:0] = irq_enable;
			end
			acc_pkg::ADDR_EVT_COUNT: begin
				next_prdata[acc_pkg::COUNT_WIDTH-1:0] = event_count;
			end
			acc_pkg::ADDR_LIVE: begin
				next_prdata[0] = result_live;
				next_prdata[1] = irq_level;
			end
			default: begin
				next_prdata = acc_pkg::PRDATA_RESET;
			end
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flop in
	// the access cycle; the trade is that status is one cycle old.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= acc_pkg::PRDATA_RESET;
		end else if (rd_setup) begin
			prdata <= next_prdata;
		end
	end

endmodule

// ---- verification/acc_comparator_model.sv ----
// Behavioural model of the analog comparator core.
`timescale 1ns/100ps

module acc_comparator_model #(
	parameter logic [11:0] BANDGAP_MV = 12'h04B0
) (
	input  wire logic        reference_select,
	input  wire logic [11:0] pos_mv,
	input  wire logic [11:0] neg_mv,
	output logic             compare_raw
);
	// The core keeps comparing while the block is disabled, so any
	// gating seen at the block's outputs has to come from the block.
	assign compare_raw =
		(reference_select ? BANDGAP_MV : pos_mv) > neg_mv;
endmodule

// ---- verification/acc_top_sva.sv ----
// Port assertions for the comparator control block.
`timescale 1ns/100ps

module acc_top_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        stop_wake_clear,
	input wire logic        wait_mode,
	input wire logic        comparator_enable,
	input wire logic        reference_select,
	input wire logic        result_output_pin,
	input wire logic        result_output_pin_oe,
	input wire logic        irq,
	input wire logic        wake_request
);
	logic wr_c;
	logic rd_c;
	assign wr_c = psel && penable && pwrite && pstrb[0] && !stop_wake_clear
		&& paddr == acc_pkg::ADDR_CTRL;
	assign rd_c = psel && penable && !pwrite && paddr == acc_pkg::ADDR_CTRL;
	default clocking dcb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_EN_WR: assert property (
		wr_c |=> comparator_enable == $past(pwdata[7]))
		else $error("enable write lost");
	AST_SEL_WR: assert property (
		wr_c |=> reference_select == $past(pwdata[6]))
		else $error("source select write lost");
	AST_EN_RD: assert property (
		rd_c |-> prdata[7] == $past(comparator_enable))
		else $error("enable read back wrong");
	AST_OFF_RD: assert property (
		rd_c && !$past(comparator_enable) |-> !prdata[3])
		else $error("result status read while disabled");
	AST_PIN_OE: assert property (
		!result_output_pin_oe |-> !result_output_pin)
		else $error("result on pin without pin enable");
	AST_PIN_EN: assert property (
		result_output_pin |-> $past(comparator_enable))
		else $error("result on pin while disabled");
	AST_WAKE: assert property (
		wake_request == (irq && $past(wait_mode)))
		else $error("wake request mismatch");
	AST_STOP: assert property (
		stop_wake_clear |=> !comparator_enable && !reference_select
		&& !irq && !wake_request && !result_output_pin_oe)
		else $error("wake clear left state behind");
endmodule

bind acc_top acc_top_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .stop_wake_clear(stop_wake_clear),
	.wait_mode(wait_mode), .comparator_enable(comparator_enable),
	.reference_select(reference_select), .irq(irq),
	.result_output_pin(result_output_pin), .wake_request(wake_request),
	.result_output_pin_oe(result_output_pin_oe));

// ---- verification/acc_top_tb.sv ----
// Self-checking testbench for the comparator control block.
`timescale 1ns/100ps

module acc_top_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hF;
	logic        stop_wake_clear = 1'b0, wait_mode = 1'b0;
	logic [11:0] pos_mv = 12'h01F4, neg_mv = 12'h03E8;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, compare_raw, comparator_enable, irq, err;
	logic        reference_select, result_output_pin, result_output_pin_oe;
	logic        wake_request;
	int          num_errors = 0;
	int          num_checks = 0;
	acc_top i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.compare_raw(compare_raw), .stop_wake_clear(stop_wake_clear),
		.wait_mode(wait_mode), .comparator_enable(comparator_enable),
		.reference_select(reference_select), .irq(irq),
		.result_output_pin(result_output_pin), .wake_request(wake_request),
		.result_output_pin_oe(result_output_pin_oe));
	acc_comparator_model i_core (.reference_select(reference_select),
		.pos_mv(pos_mv), .neg_mv(neg_mv), .compare_raw(compare_raw));
	always #25 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk(32'(got), 32'(exp));
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 16) begin
			num_errors++;
			tally_and_finish();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic ctrl_wr(input logic [7:0] d);
		apb(1'b1, acc_pkg::ADDR_CTRL, {24'h00_0000, d});
	endtask
	// Six cycles cover the two-flop synchroniser, the flag and the irq.
	task automatic analog(input logic [11:0] p, input logic [11:0] m);
		@(posedge pclk);
		pos_mv <= p;
		neg_mv <= m;
		repeat (6) @(posedge pclk);
	endtask
	task automatic flag_is(input logic f, input logic ie);
		apb(1'b0, acc_pkg::ADDR_CTRL, 32'h0000_0000);
		chkb(rd[5], f);
		chkb(irq, f & ie);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_enable_pin();
		rd_chk(acc_pkg::ADDR_CTRL, 32'h0000_0000);
		analog(12'h07D0, 12'h03E8);
		rd_chk(acc_pkg::ADDR_CTRL, 32'h0000_0000);
		ctrl_wr(8'h84);
		repeat (3) @(posedge pclk);
		chkb(result_output_pin_oe & result_output_pin, 1'b1);
		rd_chk(acc_pkg::ADDR_CTRL, 32'h0000_008C);
		ctrl_wr(8'h80);
		repeat (3) @(posedge pclk);
		chkb(result_output_pin_oe | result_output_pin, 1'b0);
		analog(12'h01F4, 12'h03E8);
		rd_chk(acc_pkg::ADDR_CTRL, 32'h0000_00A0);
		ctrl_wr(8'hE0);
		repeat (6) @(posedge pclk);
		rd_chk(acc_pkg::ADDR_CTRL, 32'h0000_00C8);
		chkb(reference_select, 1'b1);
		analog(12'h01F4, 12'h05DC);
		rd_chk(acc_pkg::ADDR_CTRL, 32'h0000_00E0);
	endtask
	// Interrupt enable is on for modes 0 and 1 only. The block is first
	// disabled and put back on the pin, so leaving the bandgap makes no
	// stale edge inside the first mode.
	task automatic t_modes();
		logic [7:0] c;
		ctrl_wr(8'h20);
		for (int m = 0; m < 4; m++) begin
			c = 8'hA0 | (m < 2 ? 8'h10 : 8'h00) | 8'(m);
			analog(12'h01F4, 12'h03E8);
			ctrl_wr(c);
			analog(12'h07D0, 12'h03E8);
			flag_is(m == 1 || m == 3, m < 2);
			ctrl_wr(c);
			analog(12'h01F4, 12'h03E8);
			flag_is(m != 1, m < 2);
			ctrl_wr(c & 8'hDF);
			flag_is(m != 1, m < 2);
			ctrl_wr(c);
			flag_is(1'b0, m < 2);
		end
	endtask
	task automatic t_wait_stop();
		ctrl_wr(8'hB1);
		analog(12'h01F4, 12'h03E8);
		ctrl_wr(8'hB1);
		wait_mode <= 1'b1;
		analog(12'h07D0, 12'h03E8);
		chkb(irq & wake_request, 1'b1);
		stop_wake_clear <= 1'b1;
		@(posedge pclk);
		stop_wake_clear <= 1'b0;
		wait_mode <= 1'b0;
		@(posedge pclk);
		chkb(comparator_enable | irq | wake_request, 1'b0);
		rd_chk(acc_pkg::ADDR_CTRL, 32'h0000_0000);
		rd_chk(acc_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
	endtask
	// The second rise lands while the flag is still set, so it is lost.
	task automatic t_irq_regs();
		ctrl_wr(8'h81);
		analog(12'h01F4, 12'h03E8);
		analog(12'h07D0, 12'h03E8);
		rd_chk(acc_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
		apb(1'b1, acc_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
		apb(1'b1, acc_pkg::ADDR_IRQ_EN, 32'h0000_0002);
		rd_chk(acc_pkg::ADDR_IRQ_EN, 32'h0000_0002);
		chkb(irq, 1'b1);
		apb(1'b1, acc_pkg::ADDR_IRQ_CLR, 32'h0000_0002);
		rd_chk(acc_pkg::ADDR_IRQ_STAT, 32'h0000_0005);
		chkb(irq, 1'b0);
		rd_chk(acc_pkg::ADDR_LIVE, 32'h0000_0001);
		rd_chk(acc_pkg::ADDR_EVT_COUNT, 32'h0000_0001);
		analog(12'h01F4, 12'h03E8);
		analog(12'h07D0, 12'h03E8);
		rd_chk(acc_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
		rd_chk(acc_pkg::ADDR_EVT_COUNT, 32'h0000_0002);
		apb(1'b1, acc_pkg::ADDR_EVT_COUNT, 32'h0000_0000);
		rd_chk(acc_pkg::ADDR_EVT_COUNT, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({rd[30:0], err}, 32'h0000_0001);
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_enable_pin();
		t_modes();
		t_wait_stop();
		t_irq_regs();
		tally_and_finish();
	end
endmodule
